//--- src/adp_decoder.sv
// system address decoder with protection, flash gating and system-call dispatch
`timescale 1ns/10ps
`default_nettype none
module adp_decoder (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // access request
    input wire logic req_valid_i,
    input wire logic [31:0] req_addr_i,
    input wire logic req_write_i,
    input wire logic req_fetch_i,
    input wire logic req_priv_i,
    input wire logic req_secure_i,
    input wire logic [1:0] req_master_i,
    input wire logic [2:0] req_ctx_i,
    // guard configuration
    input wire logic cfg_mem_we_i,
    input wire logic cfg_peri_we_i,
    input wire logic [2:0] cfg_ctx_i,
    input wire logic [31:0] cfg_base_i,
    input wire logic [31:0] cfg_limit_i,
    input wire logic [4:0] cfg_perm_i,
    // system state
    input wire logic lifecycle_secure_i,
    input wire logic ultra_low_power_mode_i,
    input wire logic [adp_pkg::SRAM_BLOCKS-1:0] sram_block_on_i,
    input wire logic [adp_pkg::SRAM_BLOCKS-1:0] sram_block_retain_i,
    // system calls: primary core, secondary core, debug access port
    input wire logic [2:0] sys_call_req_i,
    // fuses
    input wire logic fuse_prog_i,
    input wire logic [9:0] fuse_prog_idx_i,
    input wire logic [2:0] fuse_ctx_i,
    input wire logic [9:0] fuse_rd_idx_i,
    // response
    output logic rsp_valid_o,
    output logic rsp_err_o,
    output logic [3:0] rsp_target_o,
    output logic rsp_core_local_o,
    output logic [15:0] rsp_flash_word_o,
    output logic [10:0] rsp_flash_row_o,
    output logic [3:0] rsp_sram_block_o,
    output logic [adp_pkg::SRAM_BLOCKS-1:0] sram_sleep_keep_o,
    output logic secondary_nmi_o,
    output logic fuse_bit_o,
    output logic fuse_err_o
);
    logic rsp_valid_reg;
    logic rsp_err_reg;
    logic [3:0] rsp_target_reg;
    logic rsp_core_local_reg;
    logic [15:0] flash_word_reg;
    logic [10:0] flash_row_reg;
    logic [3:0] sram_block_reg;
    logic [adp_pkg::SRAM_BLOCKS-1:0] sram_keep_reg;
    logic nmi_reg;
    logic mem_allow;
    logic peri_allow;

    // window decode; master id never enters it, so both cores share the map
    wire [31:0] a = req_addr_i;
    wire in_code = adp_pkg::in_range(a, adp_pkg::CODE_LO, adp_pkg::CODE_HI);
    wire in_data = adp_pkg::in_range(a, adp_pkg::DATA_LO, adp_pkg::DATA_HI);
    wire in_peri = adp_pkg::in_range(a, adp_pkg::PERI_LO, adp_pkg::PERI_HI);
    wire in_xmem = adp_pkg::in_range(a, adp_pkg::XMEM_LO, adp_pkg::XMEM_HI);
    wire in_xdev = adp_pkg::in_range(a, adp_pkg::XDEV_LO, adp_pkg::XDEV_HI);
    wire in_core = adp_pkg::in_range(a, adp_pkg::CPRV_LO, adp_pkg::CPRV_HI);
    wire in_sysr = adp_pkg::in_range(a, adp_pkg::SYSR_LO, adp_pkg::SYSR_HI);

    // internal memories inside the code region
    wire in_rom = adp_pkg::in_range(a, adp_pkg::ROM_LO, adp_pkg::ROM_HI);
    wire in_sram = adp_pkg::in_range(a, adp_pkg::SRAM_LO, adp_pkg::SRAM_HI);
    wire in_flash = adp_pkg::in_range(a, adp_pkg::FLASH_LO, adp_pkg::FLASH_HI);
    wire in_auxf = adp_pkg::in_range(a, adp_pkg::AUXF_LO, adp_pkg::AUXF_HI);
    wire in_supf = adp_pkg::in_range(a, adp_pkg::SUPF_LO, adp_pkg::SUPF_HI);
    wire any_flash = in_flash || in_auxf || in_supf;

    // target selection; holes in the code region fall to none
    adp_pkg::adp_target_e tgt;
    assign tgt = in_rom ? adp_pkg::TGT_ROM :
                 in_sram ? adp_pkg::TGT_SRAM :
                 in_flash ? adp_pkg::TGT_FLASH :
                 in_auxf ? adp_pkg::TGT_AUXF :
                 in_supf ? adp_pkg::TGT_SUPF :
                 in_peri ? adp_pkg::TGT_PERI :
                 in_xmem ? adp_pkg::TGT_XMEM :
                 in_core ? adp_pkg::TGT_CORE :
                 in_sysr ? adp_pkg::TGT_SYSREG :
                 adp_pkg::TGT_NONE;

    // offsets into flash and sram for word, row and block indices
    wire [31:0] flash_base = in_flash ? adp_pkg::FLASH_LO :
                             in_auxf ? adp_pkg::AUXF_LO : adp_pkg::SUPF_LO;
    wire [31:0] flash_off = a - flash_base;
    wire [31:0] sram_off = a - adp_pkg::SRAM_LO;
    wire [15:0] flash_word = flash_off[adp_pkg::FLASH_WORD_SHIFT +: 16];
    wire [10:0] flash_row = flash_off[adp_pkg::FLASH_ROW_SHIFT +: 11];
    wire [3:0] sram_block = sram_off[adp_pkg::SRAM_BLOCK_SHIFT +: 4];

    // fetch only from code and external memory; peripherals never execute
    wire fetch_bad = req_fetch_i && !(in_code || in_xmem);
    // boot rom runs only on the secondary core in the boot context
    wire rom_bad = in_rom && !(req_master_i == adp_pkg::MST_SECONDARY
                               && req_ctx_i == adp_pkg::CTX_BOOT);
    // secure lifecycle freezes the supervisory sector
    wire supf_bad = in_supf && req_write_i && lifecycle_secure_i;
    // reads stay legal in both power modes; writes are held off in ultra low power
    wire ulp_bad = any_flash && req_write_i && ultra_low_power_mode_i;
    // the boot rom is never writable
    wire rom_wr_bad = in_rom && req_write_i;
    // a powered-down sram block cannot answer
    wire sram_bad = in_sram && !sram_block_on_i[sram_block];
    // core-private and system windows bypass the shared guards
    wire guard_bad = (in_peri && !peri_allow) ||
                     (!in_peri && !in_core && !in_sysr && !mem_allow);
    wire decode_bad = (tgt == adp_pkg::TGT_NONE) || in_data || in_xdev;
    wire err_now = decode_bad || fetch_bad || rom_bad || supf_bad || ulp_bad ||
                   rom_wr_bad || sram_bad || guard_bad;

    // guard for memories shared by masters
    adp_region_guard u_shared_region_guard (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .cfg_we_i(cfg_mem_we_i),
        .cfg_ctx_i(cfg_ctx_i),
        .cfg_base_i(cfg_base_i),
        .cfg_limit_i(cfg_limit_i),
        .cfg_perm_i(cfg_perm_i),
        .chk_addr_i(req_addr_i),
        .chk_ctx_i(req_ctx_i),
        .chk_write_i(req_write_i),
        .chk_fetch_i(req_fetch_i),
        .chk_priv_i(req_priv_i),
        .chk_secure_i(req_secure_i),
        .allow_o(mem_allow)
    );

    // guard for the peripheral register window
    adp_region_guard u_peripheral_register_guard (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .cfg_we_i(cfg_peri_we_i),
        .cfg_ctx_i(cfg_ctx_i),
        .cfg_base_i(cfg_base_i),
        .cfg_limit_i(cfg_limit_i),
        .cfg_perm_i(cfg_perm_i),
        .chk_addr_i(req_addr_i),
        .chk_ctx_i(req_ctx_i),
        .chk_write_i(req_write_i),
        .chk_fetch_i(req_fetch_i),
        .chk_priv_i(req_priv_i),
        .chk_secure_i(req_secure_i),
        .allow_o(peri_allow)
    );

    // fuse array; system half needs the boot context to program
    adp_fuse_array u_fuse (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .prog_i(fuse_prog_i),
        .prog_idx_i(fuse_prog_idx_i),
        .prog_sys_ok_i(fuse_ctx_i == adp_pkg::CTX_BOOT),
        .rd_idx_i(fuse_rd_idx_i),
        .rd_bit_o(fuse_bit_o),
        .prog_err_o(fuse_err_o)
    );

    // response stage: one cycle after the request
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rsp_valid_reg <= 1'b0;
            rsp_err_reg <= 1'b0;
            rsp_target_reg <= 4'h0;
            rsp_core_local_reg <= 1'b0;
        end else begin
            rsp_valid_reg <= req_valid_i;
            rsp_err_reg <= req_valid_i && err_now;
            rsp_target_reg <= req_valid_i ? tgt : 4'h0;
            rsp_core_local_reg <= req_valid_i && in_core && !err_now;
        end
    end

    // memory index outputs held with the response
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            flash_word_reg <= 16'h0000;
            flash_row_reg <= 11'h000;
            sram_block_reg <= 4'h0;
        end else if (req_valid_i) begin
            flash_word_reg <= any_flash ? flash_word : 16'h0000;
            flash_row_reg <= any_flash ? flash_row : 11'h000;
            sram_block_reg <= in_sram ? sram_block : 4'h0;
        end
    end

    // retention per 32 KB block, only for blocks that are powered
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sram_keep_reg <= '0;
        end else begin
            sram_keep_reg <= sram_block_on_i & sram_block_retain_i;
        end
    end

    // any system-call source raises the nmi on the secondary core one cycle later, held while the request stays high
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            nmi_reg <= 1'b0;
        end else begin
            nmi_reg <= |sys_call_req_i;
        end
    end

    assign rsp_valid_o = rsp_valid_reg;
    assign rsp_err_o = rsp_err_reg;
    assign rsp_target_o = rsp_target_reg;
    assign rsp_core_local_o = rsp_core_local_reg;
    assign rsp_flash_word_o = flash_word_reg;
    assign rsp_flash_row_o = flash_row_reg;
    assign rsp_sram_block_o = sram_block_reg;
    assign sram_sleep_keep_o = sram_keep_reg;
    assign secondary_nmi_o = nmi_reg;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    sequence s_fetch_peri;
        req_valid_i && req_fetch_i && in_peri;
    endsequence
    sequence s_error_answer;
        rsp_valid_o && rsp_err_o;
    endsequence

    a_peri_fetch_err: assert property (s_fetch_peri |=> s_error_answer)
        else $error("peripheral fetch not refused");
    a_data_hole_err: assert property (req_valid_i && a[31:29] == 3'h1 |=> s_error_answer)
        else $error("data region access not refused");
    a_xdev_hole_err: assert property (req_valid_i && in_xdev |=> rsp_err_o)
        else $error("unpopulated window answered");
    a_core_local_route: assert property (req_valid_i && in_core |=>
        rsp_target_o == adp_pkg::TGT_CORE && rsp_core_local_o == !rsp_err_o)
        else $error("core private window misrouted");
    a_sysreg_route: assert property (req_valid_i && a >= 32'he010_0000 |=>
        rsp_target_o == adp_pkg::TGT_SYSREG)
        else $error("system register window misrouted");
    a_supf_locked: assert property (req_valid_i && req_write_i && lifecycle_secure_i
        && a[31:15] == 17'h2c00 |=> rsp_err_o)
        else $error("supervisory flash written after secure");
    a_ulp_no_write: assert property (req_valid_i && req_write_i && ultra_low_power_mode_i
        && a[31:20] == 12'h100 |=> rsp_err_o && rsp_target_o == adp_pkg::TGT_FLASH)
        else $error("flash write in ultra low power");
    a_rom_owner: assert property (req_valid_i && a <= 32'h0001_ffff &&
        req_master_i != adp_pkg::MST_SECONDARY |=> rsp_err_o)
        else $error("boot rom reached by wrong master");
    a_nmi_raise: assert property ($rose(|sys_call_req_i) |=> secondary_nmi_o)
        else $error("system call did not raise nmi");
    a_flash_row: assert property (req_valid_i && in_flash |=>
        rsp_flash_row_o == $past(a[19:9]) && rsp_flash_word_o == $past(a[19:4]))
        else $error("flash row or word index wrong");
    a_sram_block: assert property (req_valid_i && in_sram && !sram_block_on_i[sram_block]
        |=> rsp_err_o ##0 rsp_sram_block_o == $past(sram_block))
        else $error("powered-off sram block answered");
endmodule
`default_nettype wire

//--- src/adp_pkg.sv
// shared constants, target codes and range helper for the address decode block
`default_nettype none
package adp_pkg;
    // architectural windows
    localparam logic [31:0] CODE_LO = 32'h0000_0000;
    localparam logic [31:0] CODE_HI = 32'h1fff_ffff;
    localparam logic [31:0] DATA_LO = 32'h2000_0000;
    localparam logic [31:0] DATA_HI = 32'h3fff_ffff;
    localparam logic [31:0] PERI_LO = 32'h4000_0000;
    localparam logic [31:0] PERI_HI = 32'h5fff_ffff;
    localparam logic [31:0] XMEM_LO = 32'h6000_0000;
    localparam logic [31:0] XMEM_HI = 32'h9fff_ffff;
    localparam logic [31:0] XDEV_LO = 32'ha000_0000;
    localparam logic [31:0] XDEV_HI = 32'hdfff_ffff;
    localparam logic [31:0] CPRV_LO = 32'he000_0000;
    localparam logic [31:0] CPRV_HI = 32'he00f_ffff;
    localparam logic [31:0] SYSR_LO = 32'he010_0000;
    localparam logic [31:0] SYSR_HI = 32'hffff_ffff;
    // internal memories
    localparam logic [31:0] ROM_LO = 32'h0000_0000;
    localparam logic [31:0] ROM_HI = 32'h0001_ffff;
    localparam logic [31:0] SRAM_LO = 32'h0800_0000;
    localparam logic [31:0] SRAM_HI = 32'h0804_7fff;
    localparam logic [31:0] FLASH_LO = 32'h1000_0000;
    localparam logic [31:0] FLASH_HI = 32'h100f_ffff;
    localparam logic [31:0] AUXF_LO = 32'h1400_0000;
    localparam logic [31:0] AUXF_HI = 32'h1400_7fff;
    localparam logic [31:0] SUPF_LO = 32'h1600_0000;
    localparam logic [31:0] SUPF_HI = 32'h1600_7fff;
    // flash geometry: 128-bit read word, 512-byte program row
    localparam int FLASH_WORD_SHIFT = 4;
    localparam int FLASH_ROW_SHIFT = 9;
    localparam int SRAM_BLOCK_SHIFT = 15;
    localparam int SRAM_BLOCKS = 9;
    // fuses
    localparam int FUSE_BITS = 1024;
    localparam int FUSE_SYS_BITS = 512;
    localparam int CTX_NUM = 8;
    localparam logic [2:0] CTX_BOOT = 3'h0;
    // permission bit positions
    localparam int PERM_RD = 0;
    localparam int PERM_WR = 1;
    localparam int PERM_EX = 2;
    localparam int PERM_USER = 3;
    localparam int PERM_NSEC = 4;
    localparam logic [4:0] PERM_RESET = 5'h00;
    // masters
    localparam logic [1:0] MST_PRIMARY = 2'h0;
    localparam logic [1:0] MST_SECONDARY = 2'h1;
    localparam logic [1:0] MST_DEBUG = 2'h2;
    localparam logic [1:0] MST_DMA = 2'h3;

    typedef enum logic [3:0] {
        TGT_NONE, TGT_ROM, TGT_SRAM, TGT_FLASH, TGT_AUXF, TGT_SUPF,
        TGT_PERI, TGT_XMEM, TGT_CORE, TGT_SYSREG
    } adp_target_e;

    function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
                                      input logic [31:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction
endpackage
`default_nettype wire

//--- src/adp_region_guard.sv
// one protection unit: a region and permission set per protection context
`timescale 1ns/10ps
`default_nettype none
module adp_region_guard (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic cfg_we_i,
    input wire logic [2:0] cfg_ctx_i,
    input wire logic [31:0] cfg_base_i,
    input wire logic [31:0] cfg_limit_i,
    input wire logic [4:0] cfg_perm_i,
    input wire logic [31:0] chk_addr_i,
    input wire logic [2:0] chk_ctx_i,
    input wire logic chk_write_i,
    input wire logic chk_fetch_i,
    input wire logic chk_priv_i,
    input wire logic chk_secure_i,
    output logic allow_o
);
    logic [31:0] base_reg [adp_pkg::CTX_NUM];
    logic [31:0] limit_reg [adp_pkg::CTX_NUM];
    logic [4:0] perm_reg [adp_pkg::CTX_NUM];

    // per-context storage; reset denies everything outside the boot context
    for (genvar g = 0; g < adp_pkg::CTX_NUM; g++) begin : g_ent
        always_ff @(posedge clk_sys_i or negedge resetn_i) begin
            if (!resetn_i) begin
                base_reg[g] <= 32'h0000_0000;
                limit_reg[g] <= 32'h0000_0000;
                perm_reg[g] <= adp_pkg::PERM_RESET;
            end else if (cfg_we_i && cfg_ctx_i == 3'(g)) begin
                base_reg[g] <= cfg_base_i;
                limit_reg[g] <= cfg_limit_i;
                perm_reg[g] <= cfg_perm_i;
            end
        end
    end

    // attribute check: range, direction, code/data, privilege, security
    wire [4:0] perm = perm_reg[chk_ctx_i];
    wire hit = adp_pkg::in_range(chk_addr_i, base_reg[chk_ctx_i], limit_reg[chk_ctx_i]);
    wire dir_ok = chk_write_i ? perm[adp_pkg::PERM_WR] : perm[adp_pkg::PERM_RD];
    wire type_ok = !chk_fetch_i || perm[adp_pkg::PERM_EX];
    wire priv_ok = chk_priv_i || perm[adp_pkg::PERM_USER];
    wire sec_ok = chk_secure_i || perm[adp_pkg::PERM_NSEC];
    // boot context always passes so secure boot can set up the units
    wire boot_ctx = (chk_ctx_i == adp_pkg::CTX_BOOT);
    assign allow_o = boot_ctx || (hit && dir_ok && type_ok && priv_ok && sec_ok);
endmodule
`default_nettype wire

//--- src/adp_fuse_array.sv
// one-time fuse array: between resets, bits only ever go from 0 to 1
`timescale 1ns/10ps
`default_nettype none
module adp_fuse_array (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic prog_i,
    input wire logic [9:0] prog_idx_i,
    input wire logic prog_sys_ok_i,
    input wire logic [9:0] rd_idx_i,
    output logic rd_bit_o,
    output logic prog_err_o
);
    logic [adp_pkg::FUSE_BITS-1:0] fuse_reg;
    // lower half is system-owned and needs the boot context
    wire sys_bit = (prog_idx_i < 10'(adp_pkg::FUSE_SYS_BITS));
    wire prog_ok = prog_i && (!sys_bit || prog_sys_ok_i);

    // blowing only sets; reset is the only path that clears a bit
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            fuse_reg <= '0;
            rd_bit_o <= 1'b0;
            prog_err_o <= 1'b0;
        end else begin
            if (prog_ok) begin
                fuse_reg[prog_idx_i] <= 1'b1;
            end
            rd_bit_o <= fuse_reg[rd_idx_i];
            prog_err_o <= prog_i && !prog_ok;
        end
    end

    a_fuse_no_clear: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        ($past(fuse_reg) & ~fuse_reg) == '0)
        else $error("fuse bit went back to zero");
    a_fuse_sys_lock: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        prog_i && sys_bit && !prog_sys_ok_i && !fuse_reg[prog_idx_i]
        |=> !fuse_reg[$past(prog_idx_i)] && prog_err_o)
        else $error("system fuse blown without boot context");
endmodule
`default_nettype wire

//--- verif/adp_master_model.sv
// bus master model that issues single accesses to the decoder
`timescale 1ns/10ps
`default_nettype none
module adp_master_model (
    input wire logic clk_sys_i,
    output logic req_valid_o,
    output logic [31:0] req_addr_o,
    output logic req_write_o,
    output logic req_fetch_o,
    output logic req_priv_o,
    output logic req_secure_o,
    output logic [1:0] req_master_o,
    output logic [2:0] req_ctx_o
);
    initial begin
        req_valid_o = 1'b0;
        req_addr_o = 32'h0;
        {req_ctx_o, req_master_o, req_secure_o, req_priv_o, req_fetch_o, req_write_o} = 9'h0;
    end
    // one request cycle; attr packs ctx, master, secure, priv, fetch, write
    task automatic access(input logic [31:0] a, input logic [8:0] at);
        @(posedge clk_sys_i);
        req_valid_o <= 1'b1;
        req_addr_o <= a;
        {req_ctx_o, req_master_o, req_secure_o, req_priv_o, req_fetch_o, req_write_o} <= at;
        @(posedge clk_sys_i);
        req_valid_o <= 1'b0;
        req_addr_o <= ~a; // idle bus never repeats the last address
        #1;
    endtask
endmodule
`default_nettype wire

//--- verif/address_decode_protection_test.sv
// self-checking bench for the address decoder
`timescale 1ns/10ps
`default_nettype none
module address_decode_protection_test;
    typedef struct packed {logic [31:0] a; logic [8:0] at; logic e; logic [3:0] t;} adp_row_s;
    // attr: ctx, master, secure, priv, fetch, write; target f is not compared
    localparam logic [8:0] RD = 9'h00c;
    localparam logic [8:0] FE = 9'h00e;
    localparam logic [8:0] WR = 9'h00d;
    adp_row_s rows [0:24] = '{
        '{32'h10000200, RD, 1'h0, 4'h3}, '{32'h20000000, RD, 1'h1, 4'h0},
        '{32'h3fffffff, RD, 1'h1, 4'h0}, '{32'h40000000, RD, 1'h0, 4'h6},
        '{32'h5fffffff, FE, 1'h1, 4'hf}, '{32'h60000000, FE, 1'h0, 4'h7},
        '{32'h9fffffff, FE, 1'h0, 4'h7}, '{32'ha0000000, RD, 1'h1, 4'h0},
        '{32'hdfffffff, RD, 1'h1, 4'h0}, '{32'he0000000, RD, 1'h0, 4'h8},
        '{32'he00fffff, RD, 1'h0, 4'h8}, '{32'he0100000, RD, 1'h0, 4'h9},
        '{32'hffffffff, RD, 1'h0, 4'h9}, '{32'h00000000, 9'h01e, 1'h0, 4'h1},
        '{32'h0001ffff, RD, 1'h1, 4'hf}, '{32'h00000100, 9'h01d, 1'h1, 4'hf},
        '{32'h00020000, RD, 1'h1, 4'h0}, '{32'h08000000, RD, 1'h0, 4'h2},
        '{32'h08047fff, WR, 1'h0, 4'h2}, '{32'h08048000, RD, 1'h1, 4'h0},
        '{32'h100fffff, FE, 1'h0, 4'h3}, '{32'h10100000, RD, 1'h1, 4'h0},
        '{32'h14007fff, WR, 1'h0, 4'h4}, '{32'h14008000, RD, 1'h1, 4'h0},
        '{32'h16000000, WR, 1'h0, 4'h5}};
    logic clk_sys_i, resetn_i = 1'b0;
    logic req_valid, req_write, req_fetch, req_priv, req_secure;
    logic [31:0] req_addr, cfg_base = 32'h0, cfg_limit = 32'h0;
    logic [1:0] req_master;
    logic [2:0] req_ctx, cfg_ctx = 3'h0, fuse_ctx = 3'h0, sys_call = 3'h0;
    logic cfg_mem_we = 1'b0, cfg_peri_we = 1'b0, lc_sec = 1'b0, ultra_low_power_mode = 1'b0, fuse_prog = 1'b0;
    logic [4:0] cfg_perm = 5'h0;
    logic [8:0] blk_on = 9'h1ff, blk_ret = 9'h0, keep;
    logic [9:0] fuse_idx = 10'h0, fuse_rd = 10'h0;
    logic rsp_valid_o, rsp_err_o, rsp_core_local_o, nmi, fuse_bit, fuse_err;
    logic [3:0] rsp_target_o, blk;
    logic [15:0] fword;
    logic [10:0] frow;
    int n_fail = 0;
    int n_compared = 0;
    adp_master_model m (.clk_sys_i(clk_sys_i), .req_valid_o(req_valid), .req_addr_o(req_addr),
        .req_write_o(req_write), .req_fetch_o(req_fetch), .req_priv_o(req_priv),
        .req_secure_o(req_secure), .req_master_o(req_master), .req_ctx_o(req_ctx));
    adp_decoder dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .req_valid_i(req_valid),
        .req_addr_i(req_addr), .req_write_i(req_write), .req_fetch_i(req_fetch),
        .req_priv_i(req_priv), .req_secure_i(req_secure), .req_master_i(req_master),
        .req_ctx_i(req_ctx), .cfg_mem_we_i(cfg_mem_we), .cfg_peri_we_i(cfg_peri_we),
        .cfg_ctx_i(cfg_ctx), .cfg_base_i(cfg_base), .cfg_limit_i(cfg_limit),
        .cfg_perm_i(cfg_perm), .lifecycle_secure_i(lc_sec), .ultra_low_power_mode_i(ultra_low_power_mode),
        .sram_block_on_i(blk_on), .sram_block_retain_i(blk_ret), .sys_call_req_i(sys_call),
        .fuse_prog_i(fuse_prog), .fuse_prog_idx_i(fuse_idx), .fuse_ctx_i(fuse_ctx),
        .fuse_rd_idx_i(fuse_rd), .rsp_valid_o(rsp_valid_o), .rsp_err_o(rsp_err_o),
        .rsp_target_o(rsp_target_o), .rsp_core_local_o(rsp_core_local_o),
        .rsp_flash_word_o(fword), .rsp_flash_row_o(frow), .rsp_sram_block_o(blk),
        .sram_sleep_keep_o(keep), .secondary_nmi_o(nmi), .fuse_bit_o(fuse_bit),
        .fuse_err_o(fuse_err));
    initial begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    // full answer of one access; core_local only for accepted core-private hits
    task automatic acc(input logic [31:0] a, input logic [8:0] at, input logic e,
                       input logic [3:0] t);
        m.access(a, at);
        chk("valid", 1'h1, rsp_valid_o);
        chk("err", e, rsp_err_o);
        if (t != 4'hf) chk("target", t, rsp_target_o);
        if (t != 4'hf) chk("local", t == 4'h8 && !e, rsp_core_local_o);
    endtask
    task automatic cfgw(input logic p, input logic [2:0] c, input logic [4:0] pm);
        @(posedge clk_sys_i);
        {cfg_peri_we, cfg_mem_we, cfg_ctx, cfg_perm} <= {p, !p, c, pm};
        cfg_base <= p ? 32'h40000000 : 32'h08000000;
        cfg_limit <= p ? 32'h5fffffff : 32'h08047fff;
        @(posedge clk_sys_i);
        {cfg_peri_we, cfg_mem_we} <= 2'h0;
    endtask
    // program one fuse, then read it back once the array has settled
    task automatic fprog(input logic [9:0] i, input logic [2:0] c, input logic e, input logic b);
        @(posedge clk_sys_i);
        {fuse_prog, fuse_idx, fuse_ctx, fuse_rd} <= {1'b1, i, c, i};
        @(posedge clk_sys_i);
        fuse_prog <= 1'b0;
        #1 chk("fuse_err", e, fuse_err);
        repeat (2) @(posedge clk_sys_i);
        #1 chk("fuse_bit", b, fuse_bit);
    endtask
    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // run is under two hundred cycles; the limit leaves wide room
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        n_fail++;
        give_verdict();
    end
    initial begin
        repeat (9) @(posedge clk_sys_i);
        #1 chk("rst_valid", 1'h0, rsp_valid_o);
        @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        // second pass as secondary core; boot rom rows depend on the master
        for (int j = 0; j < 2; j++) begin
            for (int i = 0; i < 25; i++) begin
                if (j == 0 || rows[i].a >= 32'h20000)
                    acc(rows[i].a, rows[i].at | 9'(j << 4), rows[i].e, rows[i].t);
            end
        end
        $display("test map done");
        acc(32'h10000210, RD, 1'h0, 4'h3);
        chk("row", 11'h1, frow);
        chk("word", 16'h21, fword);
        lc_sec <= 1'b1;
        acc(32'h16007fff, WR, 1'h1, 4'hf);
        acc(32'h16007fff, RD, 1'h0, 4'h5);
        lc_sec <= 1'b0;
        ultra_low_power_mode <= 1'b1;
        acc(32'h10000000, WR, 1'h1, 4'hf);
        acc(32'h14000000, WR, 1'h1, 4'hf);
        acc(32'h10000000, RD, 1'h0, 4'h3);
        ultra_low_power_mode <= 1'b0;
        $display("test flash done");
        blk_on <= 9'h1fe;
        acc(32'h08007ffc, RD, 1'h1, 4'hf);
        acc(32'h08040000, RD, 1'h0, 4'h2);
        chk("blk", 4'h8, blk);
        blk_ret <= 9'h103;
        repeat (3) @(posedge clk_sys_i);
        #1 chk("keep", 9'h102, keep);
        blk_on <= 9'h1ff;
        $display("test sram done");
        acc(32'h08000000, 9'h04c, 1'h1, 4'hf);
        cfgw(1'b0, 3'h1, 5'h1f);
        acc(32'h08000000, 9'h04c, 1'h0, 4'h2);
        cfgw(1'b0, 3'h2, 5'h11);
        acc(32'h08000000, 9'h08c, 1'h0, 4'h2);
        acc(32'h08000000, 9'h08d, 1'h1, 4'hf);
        acc(32'h08000000, 9'h088, 1'h1, 4'hf);
        acc(32'h08000000, 9'h08e, 1'h1, 4'hf);
        acc(32'h40000000, 9'h0cc, 1'h1, 4'hf);
        cfgw(1'b1, 3'h3, 5'h0f);
        acc(32'h40000000, 9'h0cc, 1'h0, 4'h6);
        acc(32'h40000000, 9'h0c4, 1'h1, 4'hf);
        $display("test guard done");
        for (int b = 0; b < 3; b++) begin
            @(posedge clk_sys_i);
            sys_call <= 3'h1 << b;
            repeat (2) @(posedge clk_sys_i);
            #1 chk("nmi", 1'h1, nmi);
            sys_call <= 3'h0;
            repeat (2) @(posedge clk_sys_i);
            #1 chk("nmi_off", 1'h0, nmi);
        end
        $display("test syscall done");
        fprog(10'd600, 3'h1, 1'h0, 1'h1);
        fprog(10'd5, 3'h1, 1'h1, 1'h0);
        fprog(10'd5, 3'h0, 1'h0, 1'h1);
        fprog(10'd600, 3'h1, 1'h0, 1'h1);
        $display("test fuse done");
        sys_call <= 3'h4;
        @(posedge clk_sys_i);
        resetn_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        #1 chk("rst_nmi", 1'h0, nmi);
        resetn_i <= 1'b1;
        sys_call <= 3'h0;
        acc(32'h08000000, 9'h04c, 1'h1, 4'hf);
        $display("test reset done");
        give_verdict();
    end
endmodule
`default_nettype wire
